/* File: logic/sleep_ctl_pkg.sv */
package sleep_ctl_pkg;

  // ==========================================
  // Register map (word byte addresses)
  localparam logic [3:0] CONTROL_ADDR = 4'h0;
  localparam logic [3:0] WAKE_ADDR = 4'h4;
  localparam logic [3:0] RESET_CTL_ADDR = 4'h8;

  // ==========================================
  // Field positions
  localparam int ARM_BIT = 15;
  localparam int BROWNOUT_BIT = 1;
  localparam int RELEASE_BIT = 0;
  localparam int DEEP_FLAG_BIT = 10;
  localparam int POR_FLAG_BIT = 0;
  localparam int WAKE_INT_BIT = 8;
  localparam int WAKE_FLT_BIT = 7;
  localparam int WAKE_WDT_BIT = 4;
  localparam int WAKE_ALM_BIT = 3;
  localparam int WAKE_MASTER_CLEAR_PIN_BIT = 2;
  localparam int WAKE_POR_BIT = 0;
  localparam logic [15:0] WAKE_MASK = 16'h019d;

  // ==========================================
  // Reset values and timing
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] WAKE_RESET = 16'h0000;
  localparam int POR_SEQ_NS = 1000;
  localparam int CLK_NS = 25;
  localparam logic [7:0] POR_SEQ_CYCLES = 8'(POR_SEQ_NS / CLK_NS);

  // Wake events entering the block
  typedef struct packed {
    logic ext_int;
    logic fault;
    logic watchdog;
    logic alarm;
    logic master_clear;
    logic brownout;
  } wake_events_type;

  typedef enum logic [1:0] {RUN, DEEP, EXIT_SEQ} power_state_type;

endpackage

/* File: logic/wake_latch.sv */
`timescale 1ns/1ps
// One sticky wake-source bit: hardware set wins over software clear
module wake_latch
(
  input wire logic CLK,
  input wire logic clr,
  input wire logic set,
  input wire logic wr,
  input wire logic wdata,
  output logic q
);
  logic q_reg;
  logic q_next;

  // ==========================================
  // Next value
  always_comb
  begin
    q_next = q_reg;
    if (clr)
      q_next = 1'b0;
    else if (set)
      q_next = 1'b1;
    else if (wr && !wdata)
      q_next = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    q_reg <= q_next;
  end

  assign q = q_reg;
endmodule

/* File: logic/deep_sleep_status_control.sv */
`timescale 1ns/1ps
module deep_sleep_status_control
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SLEEP_REQ,
  input wire sleep_ctl_pkg::wake_events_type WAKE_IN,
  input wire logic POR_EVENT,
  output logic DEEP_SLEEP,
  output logic NORMAL_SLEEP,
  output logic PIN_HOLD
);
  import sleep_ctl_pkg::*;

  // SRST is the true power-on reset; it clears everything here except the power-on flag and AVS_WAITREQUEST, which it sets
  power_state_type state_reg, state_next;
  logic [7:0] seq_cnt_reg, seq_cnt_next;
  logic arm_reg, arm_next;
  logic brownout_reg, brownout_next;
  logic release_reg, release_next;
  logic deep_flag_reg, deep_flag_next;
  logic por_flag_reg, por_flag_next;
  logic [31:0] rdata_next;
  logic ack_reg, ack_next;
  logic norm_next;
  logic [15:0] wake_q;
  logic [15:0] wake_set;
  logic in_deep;
  logic wr_wake;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    return a == b;
  endfunction

  assign in_deep = (state_reg == DEEP);
  // Only writes enabling both low byte lanes carry the 16-bit registers
  assign wr_wake = AVS_WRITE && !ack_reg && hit(AVS_ADDRESS, WAKE_ADDR) && (AVS_BYTEENABLE[1:0] == 2'h3);

  // ==========================================
  // Wake-source set terms
  always_comb
  begin
    wake_set = 16'h0000;
    wake_set[WAKE_INT_BIT] = in_deep && WAKE_IN.ext_int;
    wake_set[WAKE_FLT_BIT] = in_deep && WAKE_IN.fault;
    wake_set[WAKE_WDT_BIT] = in_deep && WAKE_IN.watchdog;
    wake_set[WAKE_ALM_BIT] = in_deep && WAKE_IN.alarm;
    wake_set[WAKE_MASTER_CLEAR_PIN_BIT] = in_deep && WAKE_IN.master_clear;
    wake_set[WAKE_POR_BIT] = POR_EVENT;
  end

  // ==========================================
  // Wake-source latches, one per implemented bit
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : gen_wake
      if (WAKE_MASK[g])
      begin : gen_bit
        wake_latch u_latch
        (
          .CLK(CLK),
          .clr(SRST),
          .set(wake_set[g]),
          .wr(wr_wake),
          .wdata(AVS_WRITEDATA[g]),
          .q(wake_q[g])
        );
      end
      else
      begin : gen_zero
        assign wake_q[g] = 1'b0;
      end
    end
  endgenerate

  // ==========================================
  // Power state and control bits
  always_comb
  begin
    state_next = state_reg;
    seq_cnt_next = seq_cnt_reg;
    arm_next = arm_reg;
    brownout_next = brownout_reg;
    release_next = release_reg;
    deep_flag_next = deep_flag_reg;
    por_flag_next = por_flag_reg || POR_EVENT;
    norm_next = 1'b0;
    case (state_reg)
      RUN:
      begin
        if (SLEEP_REQ && arm_reg)
        begin
          state_next = DEEP;
          deep_flag_next = 1'b1;
        end
        else if (SLEEP_REQ)
          norm_next = 1'b1;
      end
      DEEP:
      begin
        if (WAKE_IN.brownout)
          brownout_next = 1'b1;
        // Brown-out is not a wake term on purpose
        if (WAKE_IN.ext_int || WAKE_IN.fault || WAKE_IN.watchdog || WAKE_IN.alarm ||
            WAKE_IN.master_clear || POR_EVENT)
        begin
          state_next = EXIT_SEQ;
          seq_cnt_next = POR_SEQ_CYCLES;
          arm_next = 1'b0;
          release_next = 1'b1;
          por_flag_next = 1'b1;
        end
      end
      EXIT_SEQ:
      begin
        // Events other than POR_EVENT are dropped here since in_deep is low
        if (seq_cnt_reg == 8'h00)
          state_next = RUN;
        else
          seq_cnt_next = seq_cnt_reg - 8'h01;
      end
      default:
        state_next = RUN;
    endcase
    if (AVS_WRITE && !ack_reg && AVS_BYTEENABLE[1:0] == 2'h3 && state_reg == RUN)
    begin
      if (hit(AVS_ADDRESS, CONTROL_ADDR))
      begin
        arm_next = AVS_WRITEDATA[ARM_BIT];
        if (!AVS_WRITEDATA[RELEASE_BIT])
          release_next = 1'b0;
        if (!AVS_WRITEDATA[BROWNOUT_BIT])
          brownout_next = 1'b0;
      end
      if (hit(AVS_ADDRESS, RESET_CTL_ADDR))
      begin
        // Entry in the same cycle keeps the flag: hardware set wins over clear
        if (!AVS_WRITEDATA[DEEP_FLAG_BIT] && !(SLEEP_REQ && arm_reg))
          deep_flag_next = 1'b0;
        if (!AVS_WRITEDATA[POR_FLAG_BIT] && !POR_EVENT)
          por_flag_next = 1'b0;
      end
    end
  end

  // ==========================================
  // Bus answer: one wait cycle, then acknowledge
  always_comb
  begin
    ack_next = (AVS_READ || AVS_WRITE) && !ack_reg;
    rdata_next = 32'h0000_0000;
    if (AVS_READ && !ack_reg)
    begin
      if (hit(AVS_ADDRESS, CONTROL_ADDR))
      begin
        rdata_next[ARM_BIT] = arm_reg;
        rdata_next[BROWNOUT_BIT] = brownout_reg;
        rdata_next[RELEASE_BIT] = release_reg;
      end
      else if (hit(AVS_ADDRESS, WAKE_ADDR))
        rdata_next[15:0] = wake_q;
      else if (hit(AVS_ADDRESS, RESET_CTL_ADDR))
      begin
        rdata_next[DEEP_FLAG_BIT] = deep_flag_reg;
        rdata_next[POR_FLAG_BIT] = por_flag_reg;
      end
    end
  end

  // ==========================================
  // Registers; SRST clears the control bits, as do bus writes and, for arm, the wake exit
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state_reg <= RUN;
      seq_cnt_reg <= 8'h00;
      arm_reg <= CONTROL_RESET[ARM_BIT];
      brownout_reg <= CONTROL_RESET[BROWNOUT_BIT];
      release_reg <= CONTROL_RESET[RELEASE_BIT];
      deep_flag_reg <= 1'b0;
      por_flag_reg <= 1'b1;
      ack_reg <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
      AVS_WAITREQUEST <= 1'b1;
      DEEP_SLEEP <= 1'b0;
      NORMAL_SLEEP <= 1'b0;
      PIN_HOLD <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      seq_cnt_reg <= seq_cnt_next;
      arm_reg <= arm_next;
      brownout_reg <= brownout_next;
      release_reg <= release_next;
      deep_flag_reg <= deep_flag_next;
      por_flag_reg <= por_flag_next;
      ack_reg <= ack_next;
      AVS_READDATA <= rdata_next;
      AVS_WAITREQUEST <= !ack_next;
      DEEP_SLEEP <= (state_next == DEEP);
      NORMAL_SLEEP <= norm_next;
      PIN_HOLD <= release_next || (state_next == DEEP);
    end
  end

  // ==========================================
  // Entry and exit checks
  a_flag_on_entry: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == RUN && SLEEP_REQ && arm_reg) |=> deep_flag_reg && state_reg == DEEP)
    else $error("deep flag not set on entry");
  // Only a bus clear may drop the flag; leaving sleep must keep it for boot code
  a_flag_holds: assert property (@(posedge CLK) disable iff (SRST)
    (deep_flag_reg && !(AVS_WRITE && !ack_reg && hit(AVS_ADDRESS, RESET_CTL_ADDR))) |=> deep_flag_reg)
    else $error("deep flag lost without clear");
  a_arm_low_exit: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == EXIT_SEQ) |-> !arm_reg && !DEEP_SLEEP)
    else $error("arm set during exit");
  a_exit_clears_arm: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == DEEP ##1 state_reg == EXIT_SEQ) |-> !arm_reg && release_reg)
    else $error("arm not cleared on exit");
  a_por_flag_exit: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == DEEP ##1 state_reg == EXIT_SEQ) |-> por_flag_reg && deep_flag_reg)
    else $error("status flags wrong after exit");
  // The normal sleep strobe is registered, so it shows in the next cycle only
  a_normal_sleep: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == RUN && SLEEP_REQ && !arm_reg) |=> state_reg == RUN && NORMAL_SLEEP)
    else $error("normal sleep not taken");
  a_normal_no_deep: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == RUN && SLEEP_REQ && !arm_reg) |=> !DEEP_SLEEP)
    else $error("deep sleep taken while disarmed");

  // ==========================================
  // Wake-source checks
  a_int_sets: assert property (@(posedge CLK) disable iff (SRST)
    (in_deep && WAKE_IN.ext_int) |=> wake_q[WAKE_INT_BIT])
    else $error("interrupt bit not set");
  a_fault_sets: assert property (@(posedge CLK) disable iff (SRST)
    (in_deep && WAKE_IN.fault) |=> wake_q[WAKE_FLT_BIT])
    else $error("fault bit not set");
  a_wdt_sets: assert property (@(posedge CLK) disable iff (SRST)
    (in_deep && WAKE_IN.watchdog) |=> wake_q[WAKE_WDT_BIT])
    else $error("watchdog bit not set");
  a_alarm_sets: assert property (@(posedge CLK) disable iff (SRST)
    (in_deep && WAKE_IN.alarm) |=> wake_q[WAKE_ALM_BIT])
    else $error("alarm bit not set");
  a_master_clear_pin_sets: assert property (@(posedge CLK) disable iff (SRST)
    (in_deep && WAKE_IN.master_clear) |=> wake_q[WAKE_MASTER_CLEAR_PIN_BIT])
    else $error("master clear bit not set");
  a_por_sets: assert property (@(posedge CLK) disable iff (SRST)
    POR_EVENT |=> wake_q[WAKE_POR_BIT])
    else $error("power-on bit not set");
  a_int_only_deep: assert property (@(posedge CLK) disable iff (SRST)
    $rose(wake_q[WAKE_INT_BIT]) |-> $past(state_reg) == DEEP)
    else $error("wake bit set outside deep sleep");
  a_flt_only_deep: assert property (@(posedge CLK) disable iff (SRST)
    $rose(wake_q[WAKE_FLT_BIT]) |-> $past(state_reg) == DEEP)
    else $error("fault bit set outside deep sleep");
  a_other_only_deep: assert property (@(posedge CLK) disable iff (SRST)
    ($rose(wake_q[WAKE_WDT_BIT]) || $rose(wake_q[WAKE_ALM_BIT]) || $rose(wake_q[WAKE_MASTER_CLEAR_PIN_BIT])) |-> $past(state_reg) == DEEP)
    else $error("wake bit set outside deep sleep");
  a_wake_holds: assert property (@(posedge CLK) disable iff (SRST)
    (wake_q[WAKE_INT_BIT] && !wr_wake) |=> wake_q[WAKE_INT_BIT])
    else $error("wake bit lost without clear");

  // ==========================================
  // Exit sequence checks
  a_exit_seq_len: assert property (@(posedge CLK) disable iff (SRST)
    $rose(state_reg == EXIT_SEQ) |-> (state_reg == EXIT_SEQ)[*8])
    else $error("exit sequence too short");
  // Counter loads 40 and counts down to zero: 41 cycles in the exit sequence
  a_exit_seq_end: assert property (@(posedge CLK) disable iff (SRST)
    $rose(state_reg == EXIT_SEQ) |-> ##40 state_reg == EXIT_SEQ ##1 state_reg == RUN)
    else $error("exit sequence length wrong");
  // Late events must not leave a trace; only the supply bit may still rise
  a_exit_drops_events: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == EXIT_SEQ) |=> ((wake_q & ~$past(wake_q)) & 16'hfffe) == 16'h0000)
    else $error("wake event recorded during exit");
  a_exit_keeps_release: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == EXIT_SEQ) |=> release_reg && !arm_reg)
    else $error("control bits changed during exit");

  // ==========================================
  // Control bit and pin checks
  a_brownout_no_wake: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == DEEP && WAKE_IN.brownout && !WAKE_IN.ext_int && !WAKE_IN.fault && !WAKE_IN.watchdog &&
     !WAKE_IN.alarm && !WAKE_IN.master_clear && !POR_EVENT) |=> state_reg == DEEP && brownout_reg)
    else $error("brownout woke device");
  a_brownout_deep_only: assert property (@(posedge CLK) disable iff (SRST)
    $rose(brownout_reg) |-> $past(state_reg) == DEEP)
    else $error("brownout flag set outside deep sleep");
  a_release_hold: assert property (@(posedge CLK) disable iff (SRST)
    release_reg |-> PIN_HOLD)
    else $error("pins released while release set");
  a_pin_hold_deep: assert property (@(posedge CLK) disable iff (SRST)
    DEEP_SLEEP |-> PIN_HOLD)
    else $error("pins not held in deep sleep");
  a_unimpl_zero: assert property (@(posedge CLK) disable iff (SRST)
    (wake_q & ~WAKE_MASK) == 16'h0000 && AVS_READDATA[31:16] == 16'h0000)
    else $error("unimplemented bits nonzero");
  a_unimpl_ctl: assert property (@(posedge CLK) disable iff (SRST)
    (AVS_READ && !ack_reg && hit(AVS_ADDRESS, CONTROL_ADDR)) |=> AVS_READDATA[14:2] == 13'h0000)
    else $error("unimplemented control bits nonzero");
  a_unimpl_wake: assert property (@(posedge CLK) disable iff (SRST)
    (AVS_READ && !ack_reg && hit(AVS_ADDRESS, WAKE_ADDR)) |=> (AVS_READDATA[15:0] & ~WAKE_MASK) == 16'h0000)
    else $error("unimplemented wake bits nonzero");
endmodule

/* File: bench/deep_sleep_status_control_tb.sv */
`timescale 1ns/1ps
module deep_sleep_status_control_tb;
  import sleep_ctl_pkg::*;

  // ==========================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic sleep_req = 1'b0;
  wake_events_type wake_in = '0;
  logic por_event = 1'b0;
  logic deep_sleep;
  logic normal_sleep;
  logic pin_hold;
  int fail_count = 0;
  int compares = 0;
  // One wake source per row: event vector, expected wake source and control values
  typedef struct packed {logic [5:0] ev; logic [15:0] wake; logic [15:0] ctl;} row_type;
  row_type rows [5] = '{'{6'h20, 16'h0100, 16'h0003}, '{6'h10, 16'h0080, 16'h0001},
    '{6'h08, 16'h0010, 16'h0001}, '{6'h04, 16'h0008, 16'h0001}, '{6'h02, 16'h0004, 16'h0001}};

  // Half-period toggle gives 25 ns
  always #12.5 clk = ~clk;

  deep_sleep_status_control i_deep_sleep_status_control
  (
    .CLK(clk),
    .SRST(srst),
    .AVS_ADDRESS(address),
    .AVS_READ(read),
    .AVS_WRITE(write),
    .AVS_WRITEDATA(writedata),
    .AVS_BYTEENABLE(byteenable),
    .AVS_READDATA(readdata),
    .AVS_WAITREQUEST(waitrequest),
    .SLEEP_REQ(sleep_req),
    .WAKE_IN(wake_in),
    .POR_EVENT(por_event),
    .DEEP_SLEEP(deep_sleep),
    .NORMAL_SLEEP(normal_sleep),
    .PIN_HOLD(pin_hold)
  );

  // ==========================================
  // Compare and bus tasks
  task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_reg(name, {31'h0, exp}, {31'h0, got});
  endtask

  // Request held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus_xfer(input logic [3:0] a, input logic wr, input logic [15:0] d, input logic [3:0] be,
                          input logic [31:0] exp);
    @(posedge clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0, d};
    byteenable <= be;
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    if (!wr)
      check_reg("readdata", exp, readdata);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    bus_xfer(a, 1'b1, d, 4'h3, 32'h0);
  endtask

  task automatic rd16(input logic [3:0] a, input logic [15:0] exp);
    bus_xfer(a, 1'b0, 16'h0, 4'hf, {16'h0, exp});
  endtask

  // One-cycle pulses on the event and sleep inputs
  task automatic pulse(input logic [5:0] ev, input logic slp);
    @(posedge clk);
    wake_in <= ev;
    sleep_req <= slp;
    @(posedge clk);
    wake_in <= '0;
    sleep_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #(25 * 20000);
    fail_count++;
    end_of_test;
  end

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    check_bit("waitrequest", 1'b1, waitrequest);
    rd16(CONTROL_ADDR, 16'h0000);
    rd16(WAKE_ADDR, 16'h0000);
    rd16(RESET_CTL_ADDR, 16'h0001);
    // Events while running leave wake sources clear; supply event does not
    pulse(6'h3f, 1'b0);
    rd16(WAKE_ADDR, 16'h0000);
    @(posedge clk);
    por_event <= 1'b1;
    @(posedge clk);
    por_event <= 1'b0;
    rd16(WAKE_ADDR, 16'h0001);
    wr16(WAKE_ADDR, 16'h0000);
    rd16(WAKE_ADDR, 16'h0000);
    foreach (rows[i])
    begin
      wr16(CONTROL_ADDR, 16'h8000);
      pulse(6'h00, 1'b1);
      check_bit("deep_sleep", 1'b1, deep_sleep);
      check_bit("pin_hold", 1'b1, pin_hold);
      // Brown-out only in the first row: status, never a wake-up
      pulse({5'h0, rows[i].ctl[1]}, 1'b0);
      check_bit("deep_sleep", 1'b1, deep_sleep);
      pulse(rows[i].ev, 1'b0);
      // Other sources during the exit sequence must not be recorded
      pulse(~rows[i].ev & 6'h3e, 1'b0);
      repeat (50) @(posedge clk);
      check_bit("deep_sleep", 1'b0, deep_sleep);
      rd16(CONTROL_ADDR, rows[i].ctl);
      rd16(WAKE_ADDR, rows[i].wake);
      rd16(RESET_CTL_ADDR, 16'h0401);
      wr16(WAKE_ADDR, 16'h0000);
      wr16(RESET_CTL_ADDR, 16'h0000);
      check_bit("pin_hold", 1'b1, pin_hold);
      wr16(CONTROL_ADDR, 16'h0000);
      check_bit("pin_hold", 1'b0, pin_hold);
      rd16(RESET_CTL_ADDR, 16'h0000);
      rd16(WAKE_ADDR, 16'h0000);
    end
    // Arm clear: the same request takes normal sleep, shown for one cycle
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    @(posedge clk);
    check_bit("normal_sleep", 1'b1, normal_sleep);
    @(posedge clk);
    check_bit("normal_sleep", 1'b0, normal_sleep);
    check_bit("deep_sleep", 1'b0, deep_sleep);
    // Partial lanes, unmapped place and unimplemented bits
    bus_xfer(CONTROL_ADDR, 1'b1, 16'hffff, 4'h2, 32'h0);
    rd16(CONTROL_ADDR, 16'h0000);
    wr16(CONTROL_ADDR, 16'h7ffc);
    rd16(CONTROL_ADDR, 16'h0000);
    rd16(4'hc, 16'h0000);
    // True power-on reset in mid deep sleep clears everything but the power-on flag and waitrequest
    wr16(CONTROL_ADDR, 16'h8000);
    pulse(6'h00, 1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    check_bit("deep_sleep", 1'b0, deep_sleep);
    rd16(CONTROL_ADDR, 16'h0000);
    rd16(RESET_CTL_ADDR, 16'h0001);
    check_bit("pin_hold", 1'b0, pin_hold);
    rd16(WAKE_ADDR, 16'h0000);
    end_of_test;
  end
endmodule
